// *** shared/fspc_pkg.sv ***
package fspc_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int UNLOCK_SPACING_NS = 1000;
  localparam int UNLOCK_SPACING_CYC = (UNLOCK_SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UNLOCK_SETTLE_NS = 1000;
  localparam int UNLOCK_SETTLE_CYC = (UNLOCK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDRESS_ACCESS_TIME_NS = 70;
  localparam int ADDRESS_ACCESS_CYC =
    (ADDRESS_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_PULSE_NS = 40;
  localparam int WE_PULSE_CYC = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLEAR_PULSE_MIN_WIDTH_NS = 500;
  localparam int CLEAR_PULSE_MIN_WIDTH_CYC =
    (CLEAR_PULSE_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_RECOVERY_NS = 200;
  localparam int RESET_RECOVERY_CYC = (RESET_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // password layout
  // ****************************************
  localparam int PW_WORDS = 4;
  localparam int PW_WORD_W = 16;
  localparam int PW_W = 64;

  // ****************************************
  // command words (values arbitrary)
  // ****************************************
  localparam logic [11:0] CMD_ADDR = 12'h0A5;
  localparam logic [15:0] CMD_PROT_ENTRY = 16'h00E1;
  localparam logic [15:0] CMD_PW_UNLOCK = 16'h00C3;
  localparam logic [15:0] CMD_PROT_EXIT = 16'h00F5;

  // ****************************************
  // unlock sequence steps
  // ****************************************
  localparam logic [2:0] STEP_ENTRY = 3'h0;
  localparam logic [2:0] STEP_CMD = 3'h1;
  localparam logic [2:0] STEP_WORD0 = 3'h2;
  localparam logic [2:0] STEP_WORD3 = 3'h5;
  localparam logic [2:0] STEP_EXIT = 3'h6;

  // ****************************************
  // user operations
  // ****************************************
  typedef enum logic [1:0] {
    FSPC_OP_READ = 2'h0,
    FSPC_OP_WRITE = 2'h1,
    FSPC_OP_UNLOCK = 2'h2,
    FSPC_OP_RESET = 2'h3
  } fspc_op_t;

  typedef enum logic [6:0] {
    FSPC_ST_IDLE = 7'h01,
    FSPC_ST_SPACE = 7'h02,
    FSPC_ST_BUS = 7'h04,
    FSPC_ST_SEQ = 7'h08,
    FSPC_ST_SETTLE = 7'h10,
    FSPC_ST_RST = 7'h20,
    FSPC_ST_RECOV = 7'h40
  } fspc_state_t;

  typedef enum logic [3:0] {
    FSPC_BC_IDLE = 4'h1,
    FSPC_BC_SETUP = 4'h2,
    FSPC_BC_STROBE = 4'h4,
    FSPC_BC_HOLD = 4'h8
  } fspc_bc_state_t;

endpackage

// *** logic/fspc_bus_cycle.sv ***
`timescale 1ns/100ps
`default_nettype none
module fspc_bus_cycle
  import fspc_pkg::*;
#(
  parameter int ADDR_W = 24,
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // request
  input wire logic start_i,
  input wire logic write_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  output logic done_o,
  output logic [DATA_W-1:0] rdata_o,
  // flash pins
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  input wire logic [DATA_W-1:0] dq_i,
  output logic ce_n_o,
  output logic we_n_o,
  output logic oe_n_o
);

  localparam logic [15:0] READ_CYC = 16'(ADDRESS_ACCESS_CYC + 2);
  localparam logic [15:0] WRITE_CYC = 16'(WE_PULSE_CYC);

  fspc_bc_state_t state_q;
  logic write_q;
  logic [15:0] cnt_q;
  logic [DATA_W-1:0] dq_s1_q;
  logic [DATA_W-1:0] dq_s2_q;

  // ****************************************
  // data pin synchroniser
  // ****************************************
  always_ff @(posedge clk_i) begin
    dq_s1_q <= dq_i;
    dq_s2_q <= dq_s1_q;
  end

  // ****************************************
  // one async bus cycle
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_q <= FSPC_BC_IDLE;
      write_q <= 1'b0;
      cnt_q <= 16'h0000;
      done_o <= 1'b0;
      rdata_o <= '0;
      addr_o <= '0;
      dq_o <= '0;
      dq_oe_o <= 1'b0;
      ce_n_o <= 1'b1;
      we_n_o <= 1'b1;
      oe_n_o <= 1'b1;
    end else begin
      done_o <= 1'b0;
      case (state_q)
        FSPC_BC_IDLE: begin
          if (start_i) begin
            write_q <= write_i;
            addr_o <= addr_i;
            dq_o <= wdata_i;
            dq_oe_o <= write_i;
            ce_n_o <= 1'b0;
            state_q <= FSPC_BC_SETUP;
          end
        end
        FSPC_BC_SETUP: begin
          cnt_q <= write_q ? WRITE_CYC : READ_CYC;
          we_n_o <= !write_q;
          oe_n_o <= write_q;
          state_q <= FSPC_BC_STROBE;
        end
        FSPC_BC_STROBE: begin
          if (cnt_q == 16'h0000) begin
            we_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            if (!write_q) begin
              rdata_o <= dq_s2_q;
            end
            state_q <= FSPC_BC_HOLD;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        FSPC_BC_HOLD: begin
          ce_n_o <= 1'b1;
          dq_oe_o <= 1'b0;
          done_o <= 1'b1;
          state_q <= FSPC_BC_IDLE;
        end
        default: begin
          state_q <= FSPC_BC_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// *** logic/fspc_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module fspc_host
  import fspc_pkg::*;
#(
  parameter int ADDR_W = 24,
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // user command port
  input wire logic cmd_valid_i,
  input wire logic [1:0] cmd_op_i,
  input wire logic [ADDR_W-1:0] cmd_addr_i,
  input wire logic [DATA_W-1:0] cmd_wdata_i,
  input wire logic [PW_W-1:0] cmd_pw_i,
  input wire logic wp_level_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output logic [DATA_W-1:0] rsp_data_o,
  // flash pins
  output logic [ADDR_W-1:0] flash_addr_o,
  output logic [DATA_W-1:0] flash_dq_o,
  output logic flash_dq_oe_o,
  input wire logic [DATA_W-1:0] flash_dq_i,
  output logic flash_ce_n_o,
  output logic flash_we_n_o,
  output logic flash_oe_n_o,
  output logic flash_reset_n_o,
  output logic write_protect_accel_pin_n_o
);

  localparam logic [ADDR_W-1:0] CMD_ADDR_EXT = {{(ADDR_W-12){1'b0}}, CMD_ADDR};
  localparam logic [15:0] SPACING_LOAD = 16'(UNLOCK_SPACING_CYC);
  localparam logic [15:0] SETTLE_LOAD = 16'(UNLOCK_SETTLE_CYC);
  localparam logic [15:0] RST_LOAD = 16'(CLEAR_PULSE_MIN_WIDTH_CYC);
  localparam logic [15:0] RECOV_LOAD = 16'(RESET_RECOVERY_CYC);

  fspc_state_t state_q;
  fspc_op_t op_q;
  logic [ADDR_W-1:0] base_q;
  logic [PW_W-1:0] pw_q;
  logic [2:0] step_q;
  logic [15:0] tmr_q;
  logic [15:0] space_q;
  logic bc_start_q;
  logic bc_write_q;
  logic [ADDR_W-1:0] bc_addr_q;
  logic [DATA_W-1:0] bc_wdata_q;
  logic bc_done;
  logic [DATA_W-1:0] bc_rdata;

  // ****************************************
  // unlock sequence decode
  // ****************************************
  function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] step,
                                                 input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] a;
    a = CMD_ADDR_EXT;
    if (step >= STEP_WORD0 && step <= STEP_WORD3) begin
      a = {base[ADDR_W-1:2], 2'(step - STEP_WORD0)};
    end
    return a;
  endfunction

  function automatic logic [DATA_W-1:0] seq_data(input logic [2:0] step,
                                                 input logic [PW_W-1:0] pw);
    logic [1:0] idx;
    logic [DATA_W-1:0] d;
    idx = 2'(step - STEP_WORD0);
    case (step)
      STEP_ENTRY: d = DATA_W'(CMD_PROT_ENTRY);
      STEP_CMD: d = DATA_W'(CMD_PW_UNLOCK);
      STEP_EXIT: d = DATA_W'(CMD_PROT_EXIT);
      default: d = DATA_W'(pw[{idx, 4'h0} +: PW_WORD_W]);
    endcase
    return d;
  endfunction

  // ****************************************
  // bus cycle engine
  // ****************************************
  fspc_bus_cycle #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) u_bus (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .start_i(bc_start_q),
    .write_i(bc_write_q),
    .addr_i(bc_addr_q),
    .wdata_i(bc_wdata_q),
    .done_o(bc_done),
    .rdata_o(bc_rdata),
    .addr_o(flash_addr_o),
    .dq_o(flash_dq_o),
    .dq_oe_o(flash_dq_oe_o),
    .dq_i(flash_dq_i),
    .ce_n_o(flash_ce_n_o),
    .we_n_o(flash_we_n_o),
    .oe_n_o(flash_oe_n_o)
  );

  // ****************************************
  // unlock spacing timer
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      space_q <= 16'h0000;
    end else if (state_q == FSPC_ST_SEQ && bc_done && step_q == STEP_WORD3) begin
      space_q <= SPACING_LOAD;
    end else if (space_q != 16'h0000) begin
      space_q <= space_q - 16'h0001;
    end
  end

  // ****************************************
  // protect pin, changed only between commands
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      write_protect_accel_pin_n_o <= 1'b0;
    end else if (state_q == FSPC_ST_IDLE && !(cmd_valid_i && cmd_ready_o)) begin
      write_protect_accel_pin_n_o <= wp_level_i;
    end
  end

  // ****************************************
  // command sequencer
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_q <= FSPC_ST_IDLE;
      op_q <= FSPC_OP_READ;
      base_q <= '0;
      pw_q <= '0;
      step_q <= STEP_ENTRY;
      tmr_q <= 16'h0000;
      bc_start_q <= 1'b0;
      bc_write_q <= 1'b0;
      bc_addr_q <= '0;
      bc_wdata_q <= '0;
      cmd_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_data_o <= '0;
      flash_reset_n_o <= 1'b0;
    end else begin
      bc_start_q <= 1'b0;
      rsp_valid_o <= 1'b0;
      case (state_q)
        FSPC_ST_IDLE: begin
          cmd_ready_o <= 1'b1;
          if (cmd_valid_i && cmd_ready_o) begin
            cmd_ready_o <= 1'b0;
            op_q <= fspc_op_t'(cmd_op_i);
            base_q <= cmd_addr_i;
            pw_q <= cmd_pw_i;
            step_q <= STEP_ENTRY;
            case (fspc_op_t'(cmd_op_i))
              FSPC_OP_READ, FSPC_OP_WRITE: begin
                bc_start_q <= 1'b1;
                bc_write_q <= (cmd_op_i == FSPC_OP_WRITE);
                bc_addr_q <= cmd_addr_i;
                bc_wdata_q <= cmd_wdata_i;
                state_q <= FSPC_ST_BUS;
              end
              FSPC_OP_UNLOCK: begin
                state_q <= FSPC_ST_SPACE;
              end
              default: begin
                flash_reset_n_o <= 1'b0;
                tmr_q <= RST_LOAD;
                state_q <= FSPC_ST_RST;
              end
            endcase
          end
        end
        FSPC_ST_SPACE: begin
          if (space_q == 16'h0000) begin
            bc_start_q <= 1'b1;
            bc_write_q <= 1'b1;
            bc_addr_q <= seq_addr(step_q, base_q);
            bc_wdata_q <= seq_data(step_q, pw_q);
            state_q <= FSPC_ST_SEQ;
          end
        end
        FSPC_ST_BUS: begin
          if (bc_done) begin
            rsp_valid_o <= 1'b1;
            rsp_data_o <= (op_q == FSPC_OP_READ) ? bc_rdata : '0;
            state_q <= FSPC_ST_IDLE;
          end
        end
        FSPC_ST_SEQ: begin
          if (bc_done) begin
            if (step_q == STEP_WORD3) begin
              tmr_q <= SETTLE_LOAD;
              step_q <= STEP_EXIT;
              state_q <= FSPC_ST_SETTLE;
            end else if (step_q == STEP_EXIT) begin
              rsp_valid_o <= 1'b1;
              rsp_data_o <= '0;
              state_q <= FSPC_ST_IDLE;
            end else begin
              step_q <= step_q + 3'h1;
              bc_start_q <= 1'b1;
              bc_addr_q <= seq_addr(step_q + 3'h1, base_q);
              bc_wdata_q <= seq_data(step_q + 3'h1, pw_q);
            end
          end
        end
        FSPC_ST_SETTLE: begin
          if (tmr_q == 16'h0000) begin
            bc_start_q <= 1'b1;
            bc_addr_q <= seq_addr(step_q, base_q);
            bc_wdata_q <= seq_data(step_q, pw_q);
            state_q <= FSPC_ST_SEQ;
          end else begin
            tmr_q <= tmr_q - 16'h0001;
          end
        end
        FSPC_ST_RST: begin
          if (tmr_q == 16'h0000) begin
            flash_reset_n_o <= 1'b1;
            tmr_q <= RECOV_LOAD;
            state_q <= FSPC_ST_RECOV;
          end else begin
            tmr_q <= tmr_q - 16'h0001;
          end
        end
        FSPC_ST_RECOV: begin
          flash_reset_n_o <= 1'b1;
          if (tmr_q == 16'h0000) begin
            rsp_valid_o <= 1'b1;
            rsp_data_o <= '0;
            state_q <= FSPC_ST_IDLE;
          end else begin
            tmr_q <= tmr_q - 16'h0001;
          end
        end
        default: begin
          state_q <= FSPC_ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// *** bench/fspc_host_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
// ***
// host pin checks
// ***
module fspc_host_properties
  import fspc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // user port
  input wire logic cmd_valid_i,
  input wire logic [1:0] cmd_op_i,
  input wire logic cmd_ready_o,
  input wire logic rsp_valid_o,
  // flash pins
  input wire logic flash_ce_n_o,
  input wire logic flash_we_n_o,
  input wire logic flash_oe_n_o,
  input wire logic flash_dq_oe_o,
  input wire logic flash_reset_n_o,
  input wire logic write_protect_accel_pin_n_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  logic [7:0] low_cnt_q;
  always_ff @(posedge clk_i) begin
    if (!rstn_i || flash_reset_n_o) begin
      low_cnt_q <= 8'h00;
    end else if (low_cnt_q != 8'hFF) begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end
  end
  sequence s_take(logic [1:0] op);
    cmd_valid_i && cmd_ready_o && cmd_op_i == op;
  endsequence
  sequence s_done;
    !cmd_ready_o ##1 (!rsp_valid_o && cmd_ready_o);
  endsequence
  property p_read_time;
    s_take(2'h0) |-> ##[24:26] rsp_valid_o;
  endproperty
  a_read_time: assert property (p_read_time) else $error("read late");
  property p_write_time;
    s_take(2'h1) |-> ##[14:16] rsp_valid_o;
  endproperty
  a_write_time: assert property (p_write_time) else $error("write late");
  property p_unlock_time;
    s_take(2'h2) |-> ##[300:700] rsp_valid_o;
  endproperty
  a_unlock_time: assert property (p_unlock_time) else $error("unlock time");
  property p_busy;
    cmd_valid_i && cmd_ready_o |=> !cmd_ready_o;
  endproperty
  a_busy: assert property (p_busy) else $error("ready after take");
  property p_rsp;
    rsp_valid_o |-> s_done;
  endproperty
  a_rsp: assert property (p_rsp) else $error("answer shape");
  property p_we_oe;
    !flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o;
  endproperty
  a_we_oe: assert property (p_we_oe) else $error("strobe overlap");
  property p_dq_oe;
    flash_dq_oe_o |-> flash_oe_n_o;
  endproperty
  a_dq_oe: assert property (p_dq_oe) else $error("bus fight");
  property p_wp_steady;
    !flash_ce_n_o |=> $stable(write_protect_accel_pin_n_o);
  endproperty
  a_wp_steady: assert property (p_wp_steady) else $error("protect pin moved");
  property p_rst_width;
    $rose(flash_reset_n_o) |-> low_cnt_q >= CLEAR_PULSE_MIN_WIDTH_CYC;
  endproperty
  a_rst_width: assert property (p_rst_width) else $error("reset pulse short");
  property p_rst_quiet;
    !flash_reset_n_o |-> flash_ce_n_o && flash_we_n_o;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("bus during reset");
endmodule
bind fspc_host fspc_host_properties fspc_host_properties_i (
  .clk_i, .rstn_i, .cmd_valid_i, .cmd_op_i, .cmd_ready_o, .rsp_valid_o, .flash_ce_n_o,
  .flash_we_n_o, .flash_oe_n_o, .flash_dq_oe_o, .flash_reset_n_o,
  .write_protect_accel_pin_n_o
);
`default_nettype wire

// *** bench/fspc_flash_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ***
// flash device model
// ***
module fspc_flash_model
  import fspc_pkg::*;
(
  // flash pins
  input wire logic [23:0] addr_i,
  input wire logic [15:0] dq_i,
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic reset_n_i,
  output logic [15:0] dq_o,
  // observation
  output logic lock_o,
  output logic too_fast_o
);
  logic [PW_W-1:0] pw_q = {PW_W{1'b1}};
  logic [PW_W-1:0] got_q;
  logic [2:0] step_q = STEP_ENTRY;
  logic drv_q = 1'b0;
  realtime last_t = -2000.0;
  initial begin
    lock_o = 1'b0;
    too_fast_o = 1'b0;
    dq_o = 16'h0000;
  end
  always @(posedge we_n_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lock_o <= 1'b0;
      step_q <= STEP_ENTRY;
    end else if (!ce_n_i) begin
      if (step_q == STEP_ENTRY && dq_i == CMD_PROT_ENTRY) begin
        step_q <= STEP_CMD;
      end else if (step_q == STEP_CMD) begin
        step_q <= (dq_i == CMD_PW_UNLOCK) ? STEP_WORD0 : STEP_ENTRY;
      end else if (step_q >= STEP_WORD0 && step_q <= STEP_WORD3) begin
        got_q[16 * addr_i[1:0] +: 16] = dq_i;
        step_q <= step_q + 3'h1;
        if (step_q == STEP_WORD3) begin
          if ($realtime - last_t < UNLOCK_SPACING_NS) too_fast_o <= 1'b1;
          else if (got_q == pw_q) lock_o <= #(UNLOCK_SETTLE_NS - 10) 1'b1;
          last_t = $realtime;
        end
      end else if (step_q == STEP_EXIT) begin
        step_q <= STEP_ENTRY;
      end
    end
  end
  // released bus shows the inverse of the last word
  always @(*) begin
    if (!ce_n_i && !oe_n_i && reset_n_i) begin
      dq_o = (addr_i[11:0] == CMD_ADDR) ? {15'h0000, lock_o} : addr_i[15:0] ^ 16'h5A5A;
      drv_q = 1'b1;
    end else if (drv_q) begin
      dq_o = ~dq_o;
      drv_q = 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import fspc_pkg::*;
  // ***
  // bench
  // ***
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic [1:0] cmd_op_i = 2'h0;
  logic [23:0] cmd_addr_i = 24'h000000;
  logic [15:0] cmd_wdata_i = 16'h0000;
  logic [63:0] cmd_pw_i = 64'h0;
  logic wp_level_i = 1'b0;
  logic cmd_ready_o, rsp_valid_o, dq_oe, ce_n, we_n, oe_n, rst_n, wp_n, lock, too_fast;
  logic [15:0] rsp_data_o, host_dq, mdl_dq, bus_dq, rd;
  logic [23:0] addr;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  assign bus_dq = dq_oe ? host_dq : mdl_dq;
  always #2 clk_i = ~clk_i;
  fspc_host fspc_host_i (
    .clk_i, .rstn_i, .cmd_valid_i, .cmd_op_i, .cmd_addr_i, .cmd_wdata_i, .cmd_pw_i, .wp_level_i,
    .cmd_ready_o, .rsp_valid_o, .rsp_data_o, .flash_addr_o(addr), .flash_dq_o(host_dq),
    .flash_dq_oe_o(dq_oe), .flash_dq_i(bus_dq), .flash_ce_n_o(ce_n), .flash_we_n_o(we_n),
    .flash_oe_n_o(oe_n), .flash_reset_n_o(rst_n), .write_protect_accel_pin_n_o(wp_n)
  );
  fspc_flash_model fspc_flash_model_i (
    .addr_i(addr), .dq_i(bus_dq), .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n),
    .reset_n_i(rst_n), .dq_o(mdl_dq), .lock_o(lock), .too_fast_o(too_fast)
  );
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [1:0] op, input logic [23:0] a, input logic [63:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    #1;
    cmd_op_i = op;
    cmd_addr_i = a;
    cmd_wdata_i = d[15:0];
    cmd_pw_i = d;
    cmd_valid_i = 1'b1;
    while (cmd_ready_o !== 1'b1 && n < 1000) begin
      n++;
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    #1;
    cmd_valid_i = 1'b0;
    while (rsp_valid_o !== 1'b1 && n < 2000) begin
      n++;
      @(posedge clk_i);
      #1;
    end
    if (n >= 1000) begin
      fails++;
      $display("CHECK FAILED %0t command did not complete", $time);
    end
    rd = rsp_data_o;
  endtask
  task automatic final_report;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 10000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
    cmd(2'h3, 24'h000000, 64'h0);
    cmd(2'h0, 24'h0000A5, 64'h0);
    chk(rd, 16'h0000);
    cmd(2'h2, 24'h000100, 64'h7FFF_FFFF_FFFF_FFFF);
    cmd(2'h0, 24'h0000A5, 64'h0);
    chk(rd, 16'h0000);
    cmd(2'h2, 24'h000100, {PW_W{1'b1}});
    cmd(2'h0, 24'h0000A5, 64'h0);
    chk(rd, 16'h0001);
    chk({15'h0000, too_fast}, 16'h0000);
    cmd(2'h3, 24'h000000, 64'h0);
    cmd(2'h0, 24'h0000A5, 64'h0);
    chk(rd, 16'h0000);
    cmd(2'h1, {12'h000, CMD_ADDR}, {48'h0, CMD_PW_UNLOCK});
    chk(rd, 16'h0000);
    cmd(2'h0, 24'h0000A5, 64'h0);
    chk(rd, 16'h0000);
    cmd(2'h0, 24'h001234, 64'h0);
    chk(rd, 16'h486E);
    for (int v = 1; v >= 0; v--) begin
      @(posedge clk_i);
      #1;
      wp_level_i = v[0];
      repeat (3) @(posedge clk_i);
      #1;
      chk({15'h0000, wp_n}, {15'h0000, v[0]});
    end
    fork
      cmd(2'h2, 24'h000200, 64'h0);
      begin
        repeat (60) @(posedge clk_i);
        #1;
        wp_level_i = 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        chk({15'h0000, wp_n}, 16'h0000);
      end
    join
    repeat (3) @(posedge clk_i);
    #1;
    chk({15'h0000, wp_n}, 16'h0001);
    final_report();
  end
endmodule
`default_nettype wire
